//--- verilog/spi_select_and_baud_rate.sv
/*
 spi byte engine with slave-select handling, mode fault detection and
 master baud rate generator, plus the transmit fifo in front of it.
 assumes pins reach it raw (synchronised here) and that the configuration
 is static while a byte is moving.
*/
`timescale 1ns/1ps
`default_nettype none

module spi_tx_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic clk_en,
	input wire logic [WIDTH-1:0] in_data,
	input wire logic in_valid,
	output logic in_ready,
	output logic [WIDTH-1:0] out_data,
	output logic out_valid,
	input wire logic out_ready
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic [AW:0] count;
	logic [AW-1:0] next_wr_ptr;
	logic [AW-1:0] next_rd_ptr;
	logic [AW:0] next_count;
	logic push;
	logic pop;

	assign in_ready = (count != (AW+1)'(DEPTH));
	assign out_valid = (count != '0);
	assign out_data = mem[rd_ptr];

	always_comb begin
		push = in_valid && in_ready;
		pop = out_valid && out_ready;
		next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
		next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
		next_count = count;
		if (push && !pop) begin
			next_count = count + 1'b1;
		end else if (pop && !push) begin
			next_count = count - 1'b1;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end else if (clk_en) begin
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
			count <= next_count;
			if (push) begin
				mem[wr_ptr] <= in_data;
			end
		end
	end
endmodule

module spi_select_and_baud_rate
	import spi_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic clk_en,
	input wire spi_cfg_t cfg,
	input wire logic mode_fault_clear,
	output logic mode_fault_flag,
	output logic busy,
	input wire logic [BYTE_W-1:0] tx_data,
	input wire logic tx_valid,
	output logic tx_ready,
	output logic [BYTE_W-1:0] rx_data,
	output logic rx_valid,
	input wire logic ss_n_in,
	input wire logic sck_in,
	output logic sck_out,
	output logic sck_oe,
	input wire logic mosi_in,
	output logic mosi_out,
	output logic mosi_oe,
	input wire logic miso_in,
	output logic miso_out,
	output logic miso_oe
);
	function automatic logic [6:0] half_period(input logic [2:0] code);
		case (code)
			RATE_DIV4: half_period = HALF_DIV4;
			RATE_DIV8: half_period = HALF_DIV8;
			RATE_DIV16: half_period = HALF_DIV16;
			RATE_DIV32: half_period = HALF_DIV32;
			RATE_DIV64: half_period = HALF_DIV64;
			RATE_DIV128: half_period = HALF_DIV128;
			default: half_period = HALF_NONE;
		endcase
	endfunction

	// pin synchronisers: stage one feeds stage two only
	logic [3:0] sync1;
	logic [3:0] sync2;
	logic sck_prev;
	logic ss_s;
	logic sck_s;
	logic mosi_s;
	logic miso_s;

	assign ss_s = sync2[0];
	assign sck_s = sync2[1];
	assign mosi_s = sync2[2];
	assign miso_s = sync2[3];

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			// sck stages start at its idle level, so no false edge follows reset
			sync1 <= {2'b11, cfg.clock_polarity, 1'b1};
			sync2 <= {2'b11, cfg.clock_polarity, 1'b1};
			sck_prev <= cfg.clock_polarity;
		end else if (clk_en) begin
			sync1 <= {miso_in, mosi_in, sck_in, ss_n_in};
			sync2 <= sync1;
			sck_prev <= sck_s;
		end
	end

	logic [BYTE_W-1:0] fifo_data;
	logic fifo_valid;
	logic fifo_pop;

	spi_tx_fifo #(
		.WIDTH(BYTE_W),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk_sys(clk_sys),
		.rstn(rstn),
		.clk_en(clk_en),
		.in_data(tx_data),
		.in_valid(tx_valid),
		.in_ready(tx_ready),
		.out_data(fifo_data),
		.out_valid(fifo_valid),
		.out_ready(fifo_pop)
	);

	eng_state_t state;
	eng_state_t next_state;
	logic [6:0] div_cnt;
	logic [6:0] next_div_cnt;
	logic [4:0] edge_cnt;
	logic [4:0] next_edge_cnt;
	logic [BYTE_W-1:0] tx_sh;
	logic [BYTE_W-1:0] next_tx_sh;
	logic [BYTE_W-1:0] rx_sh;
	logic [BYTE_W-1:0] next_rx_sh;
	logic out_bit;
	logic next_out_bit;
	logic sck_gen;
	logic next_sck_gen;
	logic next_mode_fault_flag;
	logic [BYTE_W-1:0] next_rx_data;
	logic next_rx_valid;

	logic is_master;
	logic is_slave;
	logic selected;
	logic fault_set;
	logic [6:0] half;
	logic ev;
	logic ev_lead;
	logic ev_level;
	logic in_bit;
	logic [BYTE_W-1:0] load_byte;

	always_comb begin
		is_master = cfg.enable && cfg.master_mode;
		is_slave = cfg.enable && !cfg.master_mode;
		// phase-1 slave with select disable ignores the pin entirely
		selected = (cfg.clock_phase && cfg.select_disable) || !ss_s;
		// low select on a master means another master wants the bus
		fault_set = is_master && !cfg.select_disable && !ss_s;
		half = half_period(cfg.rate_select_field);
		in_bit = is_master ? miso_s : mosi_s;
		load_byte = fifo_valid ? fifo_data : '0;

		next_state = state;
		next_div_cnt = div_cnt;
		next_edge_cnt = edge_cnt;
		next_tx_sh = tx_sh;
		next_rx_sh = rx_sh;
		next_out_bit = out_bit;
		next_sck_gen = sck_gen;
		next_rx_data = rx_data;
		next_rx_valid = 1'b0;
		fifo_pop = 1'b0;
		ev = 1'b0;
		ev_level = 1'b0;

		// set wins over a clear in the same cycle; select disable never clears
		next_mode_fault_flag = fault_set ||
			(mode_fault_flag && !mode_fault_clear);

		// edge source: own divider as master, sampled pin as slave
		if (is_master) begin
			if (state == ST_RUN && div_cnt == 7'h01) begin
				ev = 1'b1;
				ev_level = !sck_gen;
			end
		end else begin
			ev = (sck_s != sck_prev) && (state == ST_RUN);
			ev_level = sck_s;
		end
		ev_lead = (ev_level != cfg.clock_polarity);

		case (state)
			ST_IDLE: begin
				next_sck_gen = cfg.clock_polarity;
				next_edge_cnt = '0;
				// master waits for data and a usable rate, and stays off after a fault
				if (is_master && fifo_valid && half != HALF_NONE &&
					!mode_fault_flag && !fault_set) begin
					fifo_pop = 1'b1;
					next_state = ST_RUN;
					next_div_cnt = half;
				end else if (is_slave && selected) begin
					// an empty fifo makes the slave answer with zeros
					fifo_pop = fifo_valid;
					next_state = ST_RUN;
				end
				if (next_state == ST_RUN) begin
					if (cfg.clock_phase) begin
						next_tx_sh = load_byte;
					end else begin
						next_out_bit = load_byte[BYTE_W-1];
						next_tx_sh = {load_byte[BYTE_W-2:0], 1'b0};
					end
				end
			end
			ST_RUN: begin
				if (is_master) begin
					// half the divisor high, half low
					next_div_cnt = (div_cnt == 7'h01) ? half : div_cnt - 7'h01;
					if (ev) begin
						next_sck_gen = ev_level;
					end
				end
				if (ev) begin
					next_edge_cnt = edge_cnt + 5'h01;
					if (ev_lead != cfg.clock_phase) begin
						next_rx_sh = {rx_sh[BYTE_W-2:0], in_bit};
					end else if (edge_cnt != EDGES_PER_BYTE - 5'h01) begin
						next_out_bit = tx_sh[BYTE_W-1];
						next_tx_sh = {tx_sh[BYTE_W-2:0], 1'b0};
					end
					if (edge_cnt == EDGES_PER_BYTE - 5'h01) begin
						next_state = ST_DONE;
					end
				end
				// a fault or a dropped select ends the byte without delivery
				if ((is_master && (fault_set || mode_fault_flag)) ||
					(is_slave && !selected) || !cfg.enable) begin
					next_state = ST_IDLE;
					next_sck_gen = cfg.clock_polarity;
				end
			end
			ST_DONE: begin
				next_rx_data = rx_sh;
				next_rx_valid = 1'b1;
				next_state = ST_IDLE;
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			state <= ST_IDLE;
			div_cnt <= HALF_NONE;
			edge_cnt <= '0;
			tx_sh <= '0;
			rx_sh <= '0;
			out_bit <= 1'b0;
			sck_gen <= 1'b0;
			mode_fault_flag <= 1'b0;
			rx_data <= '0;
			rx_valid <= 1'b0;
		end else if (clk_en) begin
			state <= next_state;
			div_cnt <= next_div_cnt;
			edge_cnt <= next_edge_cnt;
			tx_sh <= next_tx_sh;
			rx_sh <= next_rx_sh;
			out_bit <= next_out_bit;
			sck_gen <= next_sck_gen;
			mode_fault_flag <= next_mode_fault_flag;
			rx_data <= next_rx_data;
			rx_valid <= next_rx_valid;
		end
	end

	// slave sampling costs two clocks of latency, hence the quarter-rate limit
	assign busy = (state != ST_IDLE);
	assign sck_out = sck_gen;
	assign mosi_out = out_bit;
	assign miso_out = out_bit;
	// a faulted master lets go of sck and mosi at once
	assign sck_oe = is_master && !mode_fault_flag;
	assign mosi_oe = is_master && !mode_fault_flag;
	assign miso_oe = is_slave && selected;
endmodule

`default_nettype wire

//--- verilog/spi_pkg.sv
/*
 package for the spi select and baud rate block: configuration carrier,
 rate codes, byte and fifo sizes, engine states.
 assumes a single system clock domain; pins arrive unsynchronised.
*/
package spi_pkg;
	localparam int BYTE_W = 8;
	localparam int FIFO_DEPTH = 16;
	localparam logic [4:0] EDGES_PER_BYTE = 5'h10;
	localparam logic [6:0] HALF_NONE = 7'h00;
	localparam logic [2:0] RATE_OFF_LO = 3'h0;
	localparam logic [2:0] RATE_DIV4 = 3'h1;
	localparam logic [2:0] RATE_DIV8 = 3'h2;
	localparam logic [2:0] RATE_DIV16 = 3'h3;
	localparam logic [2:0] RATE_DIV32 = 3'h4;
	localparam logic [2:0] RATE_DIV64 = 3'h5;
	localparam logic [2:0] RATE_DIV128 = 3'h6;
	localparam logic [6:0] HALF_DIV4 = 7'h02;
	localparam logic [6:0] HALF_DIV8 = 7'h04;
	localparam logic [6:0] HALF_DIV16 = 7'h08;
	localparam logic [6:0] HALF_DIV32 = 7'h10;
	localparam logic [6:0] HALF_DIV64 = 7'h20;
	localparam logic [6:0] HALF_DIV128 = 7'h40;

	typedef struct packed {
		logic enable;
		logic master_mode;
		logic clock_polarity;
		logic clock_phase;
		logic select_disable;
		logic [2:0] rate_select_field;
	} spi_cfg_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_RUN = 2'b01,
		ST_DONE = 2'b10
	} eng_state_t;
endpackage

//--- tb/spi_sbr_checker.sv
/*
 checker: select, mode fault and rate generator properties.
 assumes it is bound to the block's top module.
*/
`timescale 1ns/1ps
`default_nettype none
module spi_sbr_checker
	import spi_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic clk_en,
	input wire spi_cfg_t cfg,
	input wire logic mode_fault_clear,
	input wire logic mode_fault_flag,
	input wire logic busy,
	input wire logic rx_valid,
	input wire logic ss_n_in,
	input wire logic sck_out,
	input wire logic sck_oe,
	input wire logic mosi_oe,
	input wire logic miso_oe
);
	default clocking @(posedge clk_sys);
	endclocking
	default disable iff (!rstn);
	logic off;
	assign off = cfg.rate_select_field inside {RATE_OFF_LO, 3'h7};
	// three samples: the select pin passes a two-stage synchroniser
	AST_MISO_OFF: assert property ((clk_en && ss_n_in &&
		!cfg.master_mode && !cfg.select_disable)[*3] |-> !miso_oe)
		else $error("miso not released");
	AST_FAULT_SET: assert property ((clk_en && cfg.enable &&
		cfg.master_mode && !cfg.select_disable && !ss_n_in)[*3]
		|=> mode_fault_flag) else $error("fault not flagged");
	AST_FAULT_OE: assert property (mode_fault_flag
		|-> !sck_oe && !mosi_oe) else $error("driving during fault");
	AST_SELECT_DISABLE: assert property ($rose(mode_fault_flag)
		|-> !$past(cfg.select_disable)) else $error("fault while disabled");
	AST_ALWAYS_SEL: assert property (cfg.enable &&
		!cfg.master_mode && cfg.clock_phase && cfg.select_disable
		|-> miso_oe) else $error("slave not selected");
	AST_STICKY: assert property (mode_fault_flag &&
		!mode_fault_clear |=> mode_fault_flag) else $error("fault lost");
	AST_NO_CLK: assert property (cfg.master_mode && off && !busy
		|=> !busy) else $error("transfer on unusable rate");
	AST_SCK_HALF: assert property (busy && $changed(sck_out) &&
		cfg.rate_select_field == RATE_DIV8 |=> $stable(sck_out)[*3])
		else $error("sck half period short");
	COV_FAULT: cover property (mode_fault_flag);
	COV_MASTER: cover property (rx_valid && cfg.master_mode);
	COV_SLAVE: cover property (rx_valid && !cfg.master_mode);
endmodule
bind spi_select_and_baud_rate spi_sbr_checker u_chk (
	.clk_sys(clk_sys),
	.rstn(rstn),
	.clk_en(clk_en),
	.cfg(cfg),
	.mode_fault_clear(mode_fault_clear),
	.mode_fault_flag(mode_fault_flag),
	.busy(busy),
	.rx_valid(rx_valid),
	.ss_n_in(ss_n_in),
	.sck_out(sck_out),
	.sck_oe(sck_oe),
	.mosi_oe(mosi_oe),
	.miso_oe(miso_oe)
);
`default_nettype wire

//--- tb/spi_far_slave.sv
/*
 far side: plain mode 0 spi slave answering a fixed byte.
 samples mosi on rising sck and shifts miso on falling sck (modes 0 and 3).
 assumes the bench drives its select.
*/
`timescale 1ns/1ps
`default_nettype none
module spi_far_slave (
	input wire logic sel_n,
	input wire logic sck,
	input wire logic mosi,
	input wire logic [7:0] reply,
	output logic miso,
	output logic [7:0] got
);
	logic [7:0] sh;
	initial miso = 1'b0;
	initial got = 8'h00;
	always @(negedge sel_n) begin
		sh = reply;
		miso = reply[7];
	end
	// miso has no pull: a released line shows the inverse, not a held bit
	always @(posedge sel_n) miso = ~miso;
	always @(posedge sck) if (!sel_n) got <= {got[6:0], mosi};
	always @(negedge sck) if (!sel_n) begin
		sh = {sh[6:0], 1'b0};
		miso = sh[7];
	end
endmodule
`default_nettype wire

//--- tb/spi_select_and_baud_rate_tb.sv
/*
 testbench: master rates, fifo fill and drain, mode fault, slave select.
 assumes the far slave model and the bound checker.
*/
`timescale 1ns/1ps
`default_nettype none
module spi_select_and_baud_rate_tb
	import spi_pkg::*;
;
	logic clk_sys, rstn, mode_fault_clear, tx_valid, ss_n_in, sck_in;
	logic mosi_in, psel_n, mode_fault_flag, busy, tx_ready, rx_valid;
	logic sck_out, sck_oe, mosi_out, mosi_oe, miso_in, miso_out, miso_oe;
	logic prv;
	logic [7:0] tx_data, rx_data, got, hc, half, sb, rb;
	spi_cfg_t cfg;
	int n_mismatch, n_compared, i, n;
	spi_select_and_baud_rate dut (
		.clk_sys(clk_sys),
		.rstn(rstn),
		.clk_en(1'b1),
		.cfg(cfg),
		.mode_fault_clear(mode_fault_clear),
		.mode_fault_flag(mode_fault_flag),
		.busy(busy),
		.tx_data(tx_data),
		.tx_valid(tx_valid),
		.tx_ready(tx_ready),
		.rx_data(rx_data),
		.rx_valid(rx_valid),
		.ss_n_in(ss_n_in),
		.sck_in(sck_in),
		.sck_out(sck_out),
		.sck_oe(sck_oe),
		.mosi_in(mosi_in),
		.mosi_out(mosi_out),
		.mosi_oe(mosi_oe),
		.miso_in(miso_in),
		.miso_out(miso_out),
		.miso_oe(miso_oe)
	);
	spi_far_slave far (.sel_n(psel_n), .sck(sck_out), .mosi(mosi_out),
		.reply(8'h5A), .miso(miso_in), .got(got));
	initial begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end
	// cycles between sck changes; the last pair of a byte is kept
	always @(posedge clk_sys) begin
		prv <= sck_out;
		hc <= (sck_out !== prv) ? 8'h01 : hc + 8'h01;
		if (sck_out !== prv) half <= hc;
	end
	task tick(input int k);
		repeat (k) @(posedge clk_sys);
		#1;
	endtask
	task chk(input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("MISMATCH %0t seen %h exp %h", $time, seen, exp);
		end
	endtask
	task final_report;
		if (n_mismatch == 0 && n_compared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task wait_rx;
		int j;
		for (j = 0; j < 3000 && rx_valid !== 1'b1; j++) tick(1);
		if (j == 3000) begin
			n_mismatch++;
			final_report;
		end
	endtask
	initial begin
		{n_mismatch, n_compared, hc, half, prv} = '0;
		{rstn, mode_fault_clear, tx_valid, sck_in, mosi_in} = '0;
		{ss_n_in, psel_n} = 2'h3;
		cfg = 8'hC0;
		tx_data = 8'h00;
		sb = 8'h96;
		tick(3);
		rstn = 1'b1;
		for (i = 1; i < 7; i++) begin
			psel_n = 1'b0;
			cfg.rate_select_field = i[2:0];
			tx_data = 8'hC3 ^ i[7:0];
			tx_valid = 1'b1;
			tick(1);
			tx_valid = 1'b0;
			wait_rx;
			chk(half, 8'h01 << i);
			chk(got, tx_data);
			// div4 is too fast for miso through the two-stage synchroniser
			if (i > 1) chk(rx_data, 8'h5A);
			psel_n = 1'b1;
			tick(2);
		end
		// mode 3: sck idles high, the far slave still samples on rising sck
		cfg.clock_polarity = 1'b1;
		cfg.clock_phase = 1'b1;
		cfg.rate_select_field = 3'h2;
		tick(2);
		chk(sck_out, 1'b1);
		psel_n = 1'b0;
		tx_data = 8'hA5;
		tx_valid = 1'b1;
		tick(1);
		tx_valid = 1'b0;
		wait_rx;
		chk(half, 8'h04);
		chk(got, 8'hA5);
		chk(sck_out, 1'b1);
		psel_n = 1'b1;
		cfg.clock_polarity = 1'b0;
		cfg.clock_phase = 1'b0;
		tick(2);
		cfg.rate_select_field = 3'h0;
		tx_valid = 1'b1;
		n = 0;
		for (i = 0; i < 20; i++) begin
			if (tx_ready === 1'b1) n++;
			tick(1);
		end
		tx_valid = 1'b0;
		chk(n[7:0], 8'h10);
		chk({busy, sck_out}, 8'h00);
		cfg.rate_select_field = 3'h7;
		tick(20);
		chk(busy, 1'b0);
		cfg.rate_select_field = 3'h1;
		for (i = 0; i < 16; i++) begin
			tick(1);
			wait_rx;
		end
		chk(tx_ready, 1'b1);
		ss_n_in = 1'b0;
		tick(6);
		chk({mode_fault_flag, sck_oe, mosi_oe}, 8'h04);
		ss_n_in = 1'b1;
		cfg.clock_phase = 1'b1;
		cfg.select_disable = 1'b1;
		tick(4);
		cfg.select_disable = 1'b0;
		tick(4);
		chk(mode_fault_flag, 1'b1);
		cfg.select_disable = 1'b1;
		ss_n_in = 1'b0;
		mode_fault_clear = 1'b1;
		tick(1);
		mode_fault_clear = 1'b0;
		tick(6);
		chk(mode_fault_flag, 1'b0);
		ss_n_in = 1'b1;
		cfg = 8'h80;
		tick(4);
		chk(miso_oe, 1'b0);
		cfg.clock_phase = 1'b1;
		cfg.select_disable = 1'b1;
		tick(1);
		chk(miso_oe, 1'b1);
		cfg = 8'h80;
		// one byte queued so the slave answers with known data
		tx_data = 8'h3C;
		tx_valid = 1'b1;
		tick(1);
		tx_valid = 1'b0;
		ss_n_in = 1'b0;
		tick(4);
		// 200 ns sck, well under a quarter of the system clock
		for (i = 7; i >= 0; i--) begin
			mosi_in = sb[i];
			tick(4);
			rb = {rb[6:0], miso_out};
			sck_in = 1'b1;
			tick(4);
			sck_in = 1'b0;
		end
		wait_rx;
		chk(rx_data, sb);
		chk(rb, 8'h3C);
		chk(miso_oe, 1'b1);
		ss_n_in = 1'b1;
		final_report;
	end
endmodule
`default_nettype wire
